// *** eeprom_pkg.sv ***
// Package of opcodes, status layout, address map and timing for the serial EEPROM command logic
package eeprom_pkg;
    // =====================================================
    // Opcodes
    localparam logic [7:0] OP_STATUS_STORE = 8'h01;
    localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
    localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
    localparam logic [7:0] OP_LATCH_SET    = 8'h06;
    // =====================================================
    // Status register field positions
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_LATCH_BIT = 1;
    localparam int ST_GLO_BIT   = 2;
    localparam int ST_GHI_BIT   = 3;
    localparam int ST_LOCK_BIT  = 7;
    localparam logic [7:0] ST_NV_MASK = 8'h8c;
    localparam logic [7:0] ST_NV_RESET = 8'h00;
    // =====================================================
    // Address map and page
    localparam int ADDR_W    = 13;
    localparam int PAGE_SIZE = 32;
    localparam int PAGE_W    = 5;
    localparam logic [12:0] PROT_LVL1_BASE = 13'h1800;
    localparam logic [12:0] PROT_LVL2_BASE = 13'h1000;
    localparam logic [12:0] PROT_LVL3_BASE = 13'h0000;
    // =====================================================
    // Timing
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int WRITE_CYCLE_US  = 5000;
    localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_US * 1000 / (CLK_PERIOD_PS / 1000);
endpackage

// *** sync2.sv ***
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] async_i,
    input  wire logic [W-1:0] rst_val_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    // =====================================================
    // Reset takes constants only; rst_val_i is tied to literals by the parent
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            meta_ff <= '1;
            sync_ff <= '1;
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end
    assign sync_o = sync_ff;
endmodule

// *** page_buffer.sv ***
// Page buffer of write data, indexed by page offset
`timescale 1ns/10ps
module page_buffer #(
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic          mclk_i,
    input  wire logic          wr_i,
    input  wire logic [AW-1:0] wr_idx_i,
    input  wire logic [7:0]    wr_data_i,
    input  wire logic [AW-1:0] rd_idx_i,
    output logic      [7:0]    rd_data_o
);
    logic [7:0] mem_ff [DEPTH];
    logic [7:0] rd_ff;
    // =====================================================
    // Storage needs no reset; the byte count in the parent says which entries hold data
    always_ff @(posedge mclk_i)
    begin
        if (wr_i)
            mem_ff[wr_idx_i] <= wr_data_i;
        rd_ff <= mem_ff[rd_idx_i];
    end
    assign rd_data_o = rd_ff;
endmodule

// *** spi_eeprom_status_protect_write.sv ***
// Command logic of the serial EEPROM: status, write latch, protection, page write, pause
`timescale 1ns/10ps
module spi_eeprom_status_protect_write #(
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLE_CYC
) (
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        cs_n_i,
    input  wire logic        sck_i,
    input  wire logic        si_i,
    input  wire logic        guard_n_i,
    input  wire logic        pause_n_i,
    output logic             so_o,
    output logic             so_oe_n_o,
    output logic             mem_we_o,
    output logic [12:0]      mem_addr_o,
    output logic [7:0]       mem_data_o
);
    typedef enum logic [4:0] {
        ST_OPC  = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_DATA = 5'b00100,
        ST_FTCH = 5'b01000,
        ST_DEAD = 5'b10000
    } phase_e;

    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_PROG = 3'b010,
        WR_WAIT = 3'b100
    } wr_e;

    // =====================================================
    // Protection decode
    function automatic logic is_guarded(input logic [1:0] lvl, input logic [12:0] a);
        unique case (lvl)
            2'b00: is_guarded = 1'b0;
            2'b01: is_guarded = a >= eeprom_pkg::PROT_LVL1_BASE;
            2'b10: is_guarded = a >= eeprom_pkg::PROT_LVL2_BASE;
            2'b11: is_guarded = a >= eeprom_pkg::PROT_LVL3_BASE;
        endcase
    endfunction

    // =====================================================
    // Pin synchronisers
    logic [3:0] pins_s;
    sync2 #(.W(4)) u_sync (
        .mclk_i    (mclk_i),
        .resetn_i  (resetn_i),
        .async_i   ({cs_n_i, sck_i, guard_n_i, pause_n_i}),
        .rst_val_i (4'hf),
        .sync_o    (pins_s)
    );
    logic si_m_ff;
    logic si_s_ff;
    logic cs_n_s;
    logic sck_s;
    logic guard_n_s;
    logic pause_n_s;
    assign cs_n_s    = pins_s[3];
    assign sck_s     = pins_s[2];
    assign guard_n_s = pins_s[1];
    assign pause_n_s = pins_s[0];

    logic sck_d_ff;
    logic cs_d_ff;
    logic paused_ff;
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            si_m_ff  <= 1'b0;
            si_s_ff  <= 1'b0;
            sck_d_ff <= 1'b0;
            cs_d_ff  <= 1'b1;
        end
        else
        begin
            si_m_ff  <= si_i;
            si_s_ff  <= si_m_ff;
            sck_d_ff <= sck_s;
            cs_d_ff  <= cs_n_s;
        end
    end

    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    assign cs_rise  = cs_n_s && !cs_d_ff;
    // Edges are masked while paused so SCK is ignored
    assign sck_rise = !cs_n_s && !paused_ff && sck_s && !sck_d_ff;
    assign sck_fall = !cs_n_s && !paused_ff && !sck_s && sck_d_ff;

    // =====================================================
    // Serial command state
    phase_e      phase_ff, nxt_phase;
    logic [7:0]  opc_ff, nxt_opc;
    logic [7:0]  sh_ff, nxt_sh;
    logic [2:0]  bit_ff, nxt_bit;
    logic [15:0] addr_ff, nxt_addr;
    logic [1:0]  abyte_ff, nxt_abyte;
    logic [5:0]  cnt_ff, nxt_cnt;
    logic [7:0]  sdata_ff, nxt_sdata;
    logic        sgot_ff, nxt_sgot;
    logic        slong_ff, nxt_slong;
    logic [2:0]  obit_ff, nxt_obit;
    logic        so_ff, nxt_so;
    logic        nxt_paused;
    logic        buf_we;
    logic [4:0]  buf_idx;
    logic        byte_done;

    // Status and write engine state
    logic [7:0]  nv_ff, nxt_nv;
    logic        latch_ff, nxt_latch;
    wr_e         wr_ff, nxt_wr;
    logic [31:0] tmr_ff, nxt_tmr;
    logic [4:0]  pidx_ff, nxt_pidx;
    logic [5:0]  wcnt_ff, nxt_wcnt;
    logic [12:0] wbase_ff, nxt_wbase;
    logic [4:0]  wstart_ff, nxt_wstart;
    logic        is_store_ff, nxt_is_store;
    logic [7:0]  status;
    logic        busy;
    logic [7:0]  rd_data;

    assign busy   = (wr_ff != WR_IDLE);
    // Reserved bits 4..6 are forced to zero
    assign status = {nv_ff[7], 3'b000, nv_ff[3:2], latch_ff, busy};

    assign byte_done = sck_rise && (bit_ff == 3'd7);
    assign buf_we    = byte_done && (phase_ff == ST_DATA) && !busy;
    assign buf_idx   = addr_ff[4:0];

    always_comb
    begin
        nxt_phase  = phase_ff;
        nxt_opc    = opc_ff;
        nxt_sh     = sh_ff;
        nxt_bit    = bit_ff;
        nxt_addr   = addr_ff;
        nxt_abyte  = abyte_ff;
        nxt_cnt    = cnt_ff;
        nxt_sdata  = sdata_ff;
        nxt_sgot   = sgot_ff;
        nxt_slong  = slong_ff;
        nxt_obit   = obit_ff;
        nxt_so     = so_ff;
        nxt_paused = paused_ff;
        // Pause entered only while SCK low and selected; left as soon as pause_n_s is high
        if (cs_n_s)
            nxt_paused = 1'b0;
        else if (!sck_s && !pause_n_s)
            nxt_paused = 1'b1;
        else if (pause_n_s)
            nxt_paused = 1'b0;
        if (cs_n_s)
        begin
            nxt_phase = ST_OPC;
            nxt_bit   = 3'd0;
            nxt_abyte = 2'd0;
            nxt_cnt   = 6'd0;
            nxt_sgot  = 1'b0;
            nxt_slong = 1'b0;
            nxt_obit  = 3'd7;
        end
        else if (sck_rise)
        begin
            nxt_sh  = {sh_ff[6:0], si_s_ff};
            nxt_bit = bit_ff + 3'd1;
            if (byte_done)
            begin
                unique case (phase_ff)
                    ST_OPC:
                    begin
                        nxt_opc = {sh_ff[6:0], si_s_ff};
                        unique case ({sh_ff[6:0], si_s_ff})
                            eeprom_pkg::OP_STATUS_FETCH: nxt_phase = ST_FTCH;
                            eeprom_pkg::OP_PAGE_WRITE:   nxt_phase = ST_ADDR;
                            eeprom_pkg::OP_STATUS_STORE: nxt_phase = ST_DATA;
                            default:                     nxt_phase = ST_DEAD;
                        endcase
                    end
                    ST_ADDR:
                    begin
                        nxt_addr  = {addr_ff[7:0], sh_ff[6:0], si_s_ff};
                        nxt_abyte = abyte_ff + 2'd1;
                        if (abyte_ff == 2'd1)
                            nxt_phase = ST_DATA;
                    end
                    ST_DATA:
                    begin
                        if (opc_ff == eeprom_pkg::OP_STATUS_STORE)
                        begin
                            nxt_sdata = {sh_ff[6:0], si_s_ff};
                            nxt_slong = sgot_ff;
                            nxt_sgot  = 1'b1;
                        end
                        else
                        begin
                            nxt_addr = {addr_ff[15:5], addr_ff[4:0] + 5'd1};
                            if (cnt_ff != 6'd63)
                                nxt_cnt = cnt_ff + 6'd1;
                        end
                    end
                    default:
                    begin
                        nxt_phase = phase_ff;
                    end
                endcase
            end
        end
        else if (sck_fall && (phase_ff == ST_FTCH))
        begin
            nxt_so   = status[obit_ff];
            nxt_obit = obit_ff - 3'd1;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            phase_ff  <= ST_OPC;
            opc_ff    <= 8'h00;
            sh_ff     <= 8'h00;
            bit_ff    <= 3'd0;
            addr_ff   <= 16'h0000;
            abyte_ff  <= 2'd0;
            cnt_ff    <= 6'd0;
            sdata_ff  <= 8'h00;
            sgot_ff   <= 1'b0;
            slong_ff  <= 1'b0;
            obit_ff   <= 3'd7;
            so_ff     <= 1'b0;
            paused_ff <= 1'b0;
        end
        else
        begin
            phase_ff  <= nxt_phase;
            opc_ff    <= nxt_opc;
            sh_ff     <= nxt_sh;
            bit_ff    <= nxt_bit;
            addr_ff   <= nxt_addr;
            abyte_ff  <= nxt_abyte;
            cnt_ff    <= nxt_cnt;
            sdata_ff  <= nxt_sdata;
            sgot_ff   <= nxt_sgot;
            slong_ff  <= nxt_slong;
            obit_ff   <= nxt_obit;
            so_ff     <= nxt_so;
            paused_ff <= nxt_paused;
        end
    end

    page_buffer #(.DEPTH(eeprom_pkg::PAGE_SIZE), .AW(eeprom_pkg::PAGE_W)) u_page (
        .mclk_i    (mclk_i),
        .wr_i      (buf_we),
        .wr_idx_i  (buf_idx),
        .wr_data_i ({sh_ff[6:0], si_s_ff}),
        .rd_idx_i  (nxt_pidx),
        .rd_data_o (rd_data)
    );

    // =====================================================
    // Command completion at chip select rise and write engine
    logic whole;
    logic single;
    logic store_ok;
    logic page_ok;
    assign whole  = (bit_ff == 3'd0);
    assign single = (phase_ff == ST_DEAD) && whole && (opc_ff == eeprom_pkg::OP_LATCH_SET
                    || opc_ff == eeprom_pkg::OP_LATCH_CLEAR) && !sgot_ff;
    assign store_ok = cs_rise && whole && (opc_ff == eeprom_pkg::OP_STATUS_STORE) && (phase_ff == ST_DATA)
                      && sgot_ff && !slong_ff && latch_ff && !busy
                      && !(nv_ff[eeprom_pkg::ST_LOCK_BIT] && !guard_n_s);
    // Fully protected page write leaves latch as it was
    assign page_ok = cs_rise && whole && (opc_ff == eeprom_pkg::OP_PAGE_WRITE) && (phase_ff == ST_DATA)
                     && (cnt_ff != 6'd0) && latch_ff && !busy
                     && !is_guarded(nv_ff[3:2], addr_ff[12:0]);

    always_comb
    begin
        nxt_nv       = nv_ff;
        nxt_latch    = latch_ff;
        nxt_wr       = wr_ff;
        nxt_tmr      = tmr_ff;
        nxt_pidx     = pidx_ff;
        nxt_wcnt     = wcnt_ff;
        nxt_wbase    = wbase_ff;
        nxt_wstart   = wstart_ff;
        nxt_is_store = is_store_ff;
        // The opcode is latched in the same tick the phase moves; latch opcodes end in DEAD, so decode on DEAD
        if (cs_rise && single && !busy)
            nxt_latch = (opc_ff == eeprom_pkg::OP_LATCH_SET);
        unique case (wr_ff)
            WR_IDLE:
            begin
                if (store_ok)
                begin
                    nxt_nv       = (sdata_ff & eeprom_pkg::ST_NV_MASK);
                    nxt_is_store = 1'b1;
                    nxt_tmr      = 32'd0;
                    nxt_wr       = WR_WAIT;
                end
                else if (page_ok)
                begin
                    nxt_is_store = 1'b0;
                    nxt_wbase    = addr_ff[12:0];
                    // Last 32 bytes: start index is where the next byte would go
                    nxt_wcnt     = (cnt_ff > 6'd32) ? 6'd32 : cnt_ff;
                    nxt_wstart   = (cnt_ff >= 6'd32) ? addr_ff[4:0] : addr_ff[4:0] - cnt_ff[4:0];
                    nxt_pidx     = (cnt_ff >= 6'd32) ? addr_ff[4:0] : addr_ff[4:0] - cnt_ff[4:0];
                    nxt_tmr      = 32'd0;
                    nxt_wr       = WR_PROG;
                end
            end
            WR_PROG:
            begin
                nxt_pidx = pidx_ff + 5'd1;
                nxt_wcnt = wcnt_ff - 6'd1;
                if (wcnt_ff == 6'd1)
                    nxt_wr = WR_WAIT;
            end
            WR_WAIT:
            begin
                nxt_tmr = tmr_ff + 32'd1;
                if (tmr_ff >= WRITE_CYCLES - 1)
                begin
                    nxt_wr    = WR_IDLE;
                    nxt_latch = 1'b0;
                end
            end
            default:
            begin
                nxt_wr = WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            nv_ff       <= eeprom_pkg::ST_NV_RESET;
            latch_ff    <= 1'b0;
            wr_ff       <= WR_IDLE;
            tmr_ff      <= 32'd0;
            pidx_ff     <= 5'd0;
            wcnt_ff     <= 6'd0;
            wbase_ff    <= 13'h0000;
            wstart_ff   <= 5'd0;
            is_store_ff <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_addr_o  <= 13'h0000;
            mem_data_o  <= 8'h00;
        end
        else
        begin
            nv_ff       <= nxt_nv;
            latch_ff    <= nxt_latch;
            wr_ff       <= nxt_wr;
            tmr_ff      <= nxt_tmr;
            pidx_ff     <= nxt_pidx;
            wcnt_ff     <= nxt_wcnt;
            wbase_ff    <= nxt_wbase;
            wstart_ff   <= nxt_wstart;
            is_store_ff <= nxt_is_store;
            // Buffer is read one index ahead, so data lines up with its address
            mem_addr_o  <= {wbase_ff[12:5], pidx_ff};
            mem_data_o  <= rd_data;
            mem_we_o    <= (wr_ff == WR_PROG) && !is_guarded(nv_ff[3:2], {wbase_ff[12:5], pidx_ff});
        end
    end

    assign so_o      = so_ff;
    assign so_oe_n_o = cs_n_s || paused_ff || (phase_ff != ST_FTCH);
endmodule

// *** spi_eeprom_status_protect_write_monitor.sv ***
// Assertion checker on the EEPROM command logic ports
`timescale 1ns/10ps
module spi_eeprom_monitor #(
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLE_CYC
) (
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        cs_n_i,
    input  wire logic        sck_i,
    input  wire logic        si_i,
    input  wire logic        guard_n_i,
    input  wire logic        pause_n_i,
    input  wire logic        so_o,
    input  wire logic        so_oe_n_o,
    input  wire logic        mem_we_o,
    input  wire logic [12:0] mem_addr_o,
    input  wire logic [7:0]  mem_data_o
);
    // =====================================================
    // Helper counters; pages are compared from the second pulse of a write
    logic [5:0] we_cnt_ff, nxt_we_cnt;
    logic [7:0] hi_cnt_ff, nxt_hi_cnt;
    logic [7:0] page_ff,   nxt_page;
    always_comb
    begin
        nxt_we_cnt = cs_n_i ? we_cnt_ff + {5'h00, mem_we_o} : 6'h00;
        nxt_hi_cnt = cs_n_i ? hi_cnt_ff + {7'h00, hi_cnt_ff != 8'hff} : 8'h00;
        nxt_page   = mem_we_o ? mem_addr_o[12:5] : page_ff;
    end
    always_ff @(posedge mclk_i)
    begin
        we_cnt_ff <= resetn_i ? nxt_we_cnt : 6'h00;
        hi_cnt_ff <= resetn_i ? nxt_hi_cnt : 8'h00;
        page_ff   <= nxt_page;
    end
    // =====================================================
    // Properties
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_desel;
        cs_n_i [*6];
    endsequence
    sequence s_paused;
        (!pause_n_i && !cs_n_i) [*6];
    endsequence
    sequence s_sck_high;
        (!so_oe_n_o && sck_i && !cs_n_i) [*5];
    endsequence
    a_oe_desel: assert property (s_desel |-> so_oe_n_o)
        else $error("serial output driven while deselected");
    a_oe_paused: assert property (s_paused |-> so_oe_n_o)
        else $error("serial output driven while paused");
    a_so_on_fall: assert property ((!so_oe_n_o && !$past(so_oe_n_o) && !cs_n_i && !$past(cs_n_i, 5)
        && $changed(so_o)) |-> !sck_i && !$past(sck_i, 2))
        else $error("serial output changed away from a clock fall");
    a_so_hold_high: assert property (s_sck_high |-> $stable(so_o))
        else $error("serial output moved while clock high");
    a_we_desel: assert property (mem_we_o |-> cs_n_i && $past(cs_n_i, 2))
        else $error("array write while selected");
    a_we_after_rise: assert property (mem_we_o |-> hi_cnt_ff < 8'h78)
        else $error("array write long after select rise");
    a_we_max_page: assert property (we_cnt_ff <= 6'h20)
        else $error("more than one page of array writes");
    a_we_same_page: assert property (mem_we_o && we_cnt_ff >= 6'h01 |-> mem_addr_o[12:5] == page_ff)
        else $error("array write left its page");
endmodule
bind spi_eeprom_status_protect_write spi_eeprom_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) i_spi_eeprom_monitor (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i),
    .guard_n_i(guard_n_i), .pause_n_i(pause_n_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o)
);

// *** spi_host_model.sv ***
// Host SPI controller model driving select, clock and data
`timescale 1ns/10ps
module spi_host_model (
    input  wire logic mclk_i,
    input  wire logic so_i,
    input  wire logic so_oe_n_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o
);
    logic cpol;
    logic so_last;
    initial
    begin
        cpol = 1'b0;
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
        so_last = 1'b0;
    end
    // =====================================================
    // Bus cycles, half an SCK period is 20 clocks
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic start_cmd();
        sck_o = cpol;
        tick(20);
        cs_n_o = 1'b0;
        tick(20);
    endtask
    // Released output reads as the inverse of the last bit, never a lucky match
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--)
        begin
            if (cpol)
                sck_o = 1'b0;
            si_o = tx[i];
            tick(20);
            sck_o = 1'b1;
            rx[i] = so_oe_n_i ? ~so_last : so_i;
            so_last = rx[i];
            tick(20);
            if (!cpol)
                sck_o = 1'b0;
        end
    endtask
    task automatic end_cmd();
        tick(20);
        cs_n_o = 1'b1;
        si_o = ~si_o;
        tick(40);
    endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the serial EEPROM command logic
`timescale 1ns/10ps
module testbench;
    // =====================================================
    // Signals and expected state
    localparam int WCYC = 1000;
    logic        mclk = 1'b0;
    logic        resetn, cs_n, sck, si, guard_n, pause_n, so, so_oe_n, mem_we, latch;
    logic [12:0] mem_addr;
    logic [7:0]  mem_data, rx, st, nv;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          we_cnt, we_sum;

    always #2 mclk = ~mclk;

    spi_eeprom_status_protect_write #(.WRITE_CYCLES(WCYC)) i_spi_eeprom_status_protect_write (
        .mclk_i(mclk), .resetn_i(resetn), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .guard_n_i(guard_n),
        .pause_n_i(pause_n), .so_o(so), .so_oe_n_o(so_oe_n), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
        .mem_data_o(mem_data));
    spi_host_model i_host (.mclk_i(mclk), .so_i(so), .so_oe_n_i(so_oe_n), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

    always @(posedge mclk)
    begin
        if (mem_we === 1'b1)
        begin
            we_cnt++;
            we_sum += mem_data ^ mem_addr[7:0];
        end
    end
    // =====================================================
    // Checking, expectations and commands
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [7:0] exp_status();
        return nv | {6'h00, latch, 1'b0};
    endfunction
    function automatic logic prot(input logic [12:0] a);
        case (nv[3:2])
            2'b01: return a >= 13'h1800;
            2'b10: return a >= 13'h1000;
            2'b11: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    task automatic cmd1(input logic [7:0] op);
        i_host.start_cmd();
        i_host.xfer(op, 8, rx);
        i_host.end_cmd();
    endtask
    task automatic fetch(output logic [7:0] s);
        i_host.start_cmd();
        i_host.xfer(eeprom_pkg::OP_STATUS_FETCH, 8, rx);
        i_host.xfer(8'h00, 8, s);
        i_host.end_cmd();
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        fetch(st);
        while (st[0] !== 1'b0 && n < 20)
        begin
            fetch(st);
            n++;
        end
        check("idle in time", st[0], 1'b0);
    endtask
    task automatic store(input logic [7:0] d, input int nb);
        logic acc;
        acc = latch && nb == 8 && !(nv[7] && !guard_n);
        i_host.start_cmd();
        i_host.xfer(eeprom_pkg::OP_STATUS_STORE, 8, rx);
        i_host.xfer(d, nb > 8 ? 8 : nb, rx);
        if (nb > 8)
            i_host.xfer(d, nb - 8, rx);
        i_host.end_cmd();
        fetch(st);
        check("busy flag", st[0], acc);
        wait_idle();
        if (acc)
        begin
            nv = d & 8'h8c;
            latch = 1'b0;
        end
        fetch(st);
        check("status after store", st, exp_status());
    endtask
    task automatic page(input logic [15:0] a, input int n, input int part);
        logic [7:0] d;
        int         s;
        logic       ok;
        s = 0;
        ok = latch && part == 0 && !prot(a[12:0]);
        i_host.start_cmd();
        i_host.xfer(eeprom_pkg::OP_PAGE_WRITE, 8, rx);
        i_host.xfer(a[15:8], 8, rx);
        i_host.xfer(a[7:0], 8, rx);
        for (int k = 0; k < n; k++)
        begin
            d = 8'($urandom);
            i_host.xfer(d, 8, rx);
            if (k >= n - 32)
                s += d ^ {a[7:5], 5'(a[4:0] + k)};
        end
        if (part > 0)
            i_host.xfer(8'h5a, part, rx);
        we_cnt = 0;
        we_sum = 0;
        i_host.end_cmd();
        wait_idle();
        check("write count", we_cnt, ok ? (n > 32 ? 32 : n) : 0);
        check("write sum", we_sum, ok ? s : 0);
        latch = latch && !ok;
        fetch(st);
        check("status after write", st, exp_status());
    endtask
    // =====================================================
    // Watchdog and test sequence
    initial
    begin
        repeat (100000) @(posedge mclk);
        error_cnt++;
        $display("[FAIL] watchdog expected done seen running");
        print_verdict();
    end
    initial
    begin
        resetn = 1'b0;
        guard_n = 1'b1;
        pause_n = 1'b1;
        nv = 8'h00;
        latch = 1'b0;
        void'($urandom(32'hf0a2));
        repeat (3) @(posedge mclk);
        #1;
        resetn = 1'b1;
        i_host.cpol = 1'b1;
        fetch(st);
        check("status at reset", st, 8'h00);
        i_host.cpol = 1'b0;
        $display("test reset status done");
        cmd1(eeprom_pkg::OP_LATCH_SET);
        latch = 1'b1;
        i_host.start_cmd();
        i_host.xfer(eeprom_pkg::OP_STATUS_FETCH, 8, rx);
        for (int k = 0; k < 3; k++)
        begin
            if (k == 2)
            begin
                pause_n = 1'b0;
                i_host.tick(20);
                check("output in pause", so_oe_n, 1'b1);
                i_host.xfer(8'ha5, 3, rx);
                pause_n = 1'b1;
                i_host.tick(20);
            end
            i_host.xfer(8'h00, 8, st);
            check("status repeat", st, 8'h02);
        end
        i_host.end_cmd();
        cmd1(eeprom_pkg::OP_LATCH_CLEAR);
        latch = 1'b0;
        fetch(st);
        check("status after clear", st, 8'h00);
        $display("test latch, wrap and pause done");
        store(8'hff, 8);
        cmd1(eeprom_pkg::OP_LATCH_SET);
        latch = 1'b1;
        store(8'h8c, 12);
        store(8'h8c, 16);
        store(8'($urandom), 8);
        cmd1(eeprom_pkg::OP_LATCH_SET);
        latch = 1'b1;
        store(8'hf3, 8);
        guard_n = 1'b0;
        cmd1(eeprom_pkg::OP_LATCH_SET);
        latch = 1'b1;
        store(8'h0c, 8);
        guard_n = 1'b1;
        store(8'h0c, 8);
        $display("test status store done");
        for (int lv = 0; lv < 5; lv++)
        begin
            cmd1(eeprom_pkg::OP_LATCH_SET);
            latch = 1'b1;
            if (lv < 4)
                store({4'h0, lv[1:0], 2'b00}, 8);
            cmd1(eeprom_pkg::OP_LATCH_SET);
            latch = 1'b1;
            page(16'($urandom), $urandom_range(1, 4), 0);
        end
        store(8'h00, 8);
        cmd1(eeprom_pkg::OP_LATCH_SET);
        latch = 1'b1;
        page(16'hffe8, 34, 0);
        cmd1(eeprom_pkg::OP_LATCH_SET);
        latch = 1'b1;
        page(16'($urandom), 5, 4);
        cmd1(eeprom_pkg::OP_LATCH_CLEAR);
        latch = 1'b0;
        page(16'($urandom), 3, 0);
        $display("test page write done");
        print_verdict();
    end
endmodule
